// >>> core/adc_control_map.svh
// register offsets, field positions, reset values and divider counts
// assumes inclusion by the package and by the converter control module
`ifndef ADC_CONTROL_MAP_SVH
`define ADC_CONTROL_MAP_SVH

`define RESULT_BITS        12
`define PIN_COUNT          8

`define ADDR_PIN_ENABLE    8'h00
`define ADDR_CONTROL       8'h04
`define ADDR_CALIBRATION   8'h08
`define ADDR_RESULT        8'h0C
`define ADDR_STATUS        8'h10
`define ADDR_CLEAR         8'h14
`define ADDR_IRQ_ENABLE    8'h18
`define ADDR_WAKE          8'h1C

`define BIT_REF_SELECT     7
`define BIT_RATE_HI        6
`define BIT_RATE_LO        5
`define BIT_RUN            4
`define BIT_POWER          3
`define BIT_CHANNEL_HI     2
`define BIT_CHANNEL_LO     0
`define BIT_CAL_ENABLE     7
`define BIT_CAL_SIGN       6
`define BIT_MAG_HI         5
`define BIT_MAG_LO         3
`define BIT_DONE           0
`define BIT_WAKE_ENABLE    0

`define RESET_BYTE         8'h00
`define CAL_RESERVED       3'h0
`define RATE_DIV16         2'h0
`define RATE_DIV4          2'h1
`define RATE_DIV64         2'h2
`define RATE_RING          2'h3
`define LIMIT_DIV16        6'h0F
`define LIMIT_DIV4         6'h03
`define LIMIT_DIV64        6'h3F

`endif

// >>> core/adc_control_pkg.sv
// types shared by the converter control block
// assumes the register map header sits beside it
`include "adc_control_map.svh"
package adc_control_pkg;

	typedef enum logic [1:0] {
		SAR_IDLE,
		SAR_SAMPLE,
		SAR_CONVERT
	} sar_phase_type;

	typedef struct packed {
		logic [7:0]              pin_enable;
		logic                    reference_select;
		logic [1:0]              clock_rate;
		logic                    conversion_run;
		logic                    converter_power;
		logic [2:0]              channel;
		logic                    calibration_enable;
		logic                    offset_positive;
		logic [2:0]              offset_magnitude;
		logic [`RESULT_BITS-1:0] result;
		logic                    status_done;
		logic                    irq_enable_done;
		logic                    converter_wake_enable;
		logic                    shutoff;
		logic                    wake;
		logic [5:0]              divider;
		logic                    tick;
		logic                    ack;
		logic                    error;
		logic [31:0]             rdata;
	} control_state_type;

endpackage : adc_control_pkg

// >>> core/sar_link_if.sv
// signals between converter control and the approximation sequencer
// assumes both ends share one clock
interface sar_link_if #(parameter int WIDTH = 12);
	logic             start;
	logic             tick;
	logic             compare;
	logic             busy;
	logic             done;
	logic             sample;
	logic [WIDTH-1:0] trial;
	logic [WIDTH-1:0] result;

	modport control (output start, output tick, output compare,
		input busy, input done, input sample, input trial, input result);
	modport engine (input start, input tick, input compare,
		output busy, output done, output sample, output trial, output result);
endinterface : sar_link_if

// >>> core/sar_engine.sv
// successive approximation sequencer, one bit per conversion tick
// assumes the analog core compares its input against the trial code
`include "adc_control_map.svh"
module sar_engine
	import adc_control_pkg::*;
#(
	parameter int WIDTH = `RESULT_BITS
) (
	input  wire logic  clk,
	input  wire logic  resetn,
	sar_link_if.engine link
);
	localparam int IW = $clog2(WIDTH);

	typedef struct packed {
		sar_phase_type    phase;
		logic [IW-1:0]    index;
		logic [WIDTH-1:0] code;
		logic [WIDTH-1:0] result;
		logic             done;
	} sar_regs_type;

	sar_regs_type     r;
	sar_regs_type     next_r;
	logic [WIDTH-1:0] kept;

	always_comb begin
		kept = r.code;
		kept[r.index] = link.compare;
		next_r = r;
		next_r.done = 1'b0;
		case (r.phase)
			SAR_IDLE: begin
				if (link.start) begin
					next_r.phase = SAR_SAMPLE;
					next_r.code = '0;
				end
			end
			SAR_SAMPLE: begin
				// one tick of acquisition before the first trial
				if (link.tick) begin
					next_r.phase = SAR_CONVERT;
					next_r.index = IW'(WIDTH - 1);
					next_r.code[WIDTH-1] = 1'b1;
				end
			end
			SAR_CONVERT: begin
				if (link.tick) begin
					next_r.code = kept;
					if (r.index == '0) begin
						next_r.phase = SAR_IDLE;
						next_r.result = kept;
						next_r.done = 1'b1;
					end else begin
						next_r.index = r.index - 1'b1;
						next_r.code[r.index - 1'b1] = 1'b1;
					end
				end
			end
			default: next_r.phase = SAR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign link.busy   = (r.phase != SAR_IDLE);
	assign link.sample = (r.phase == SAR_SAMPLE);
	assign link.trial  = r.code;
	assign link.result = r.result;
	assign link.done   = r.done;

	a_done_ends_busy: assert property (
		@(posedge clk) disable iff (!resetn)
		link.done |-> !link.busy && $past(r.phase) == SAR_CONVERT)
		else $error("done without a finished conversion");

endmodule : sar_engine

// >>> core/adc_control.sv
// converter control: registers over APB, clock rate, pin routing, events
// assumes APB on REF_CLK and an analog core driven by the trial code
`include "adc_control_map.svh"

// Summary of operation
// - each enable bit makes the matching port-6 pin an analog input
// - pin 0 goes to comparator first, then analog channel 0, then I/O
// - reference select 0 uses supply, 1 uses external reference pin
// - shared pin: reference beats third PWM output beats digital I/O
// - rate field picks oscillator divide 16, 4, 64 or ring oscillator
// - software only sets run; hardware clears it on completion
// - power bit 0 turns the resistor reference off, 1 lets it run
// - channel field routes analog input n to the converter
// - channel changes only while done flag and run are both low
// - calibration bit 7 enables offset calibration
// - calibration bit 6 picks positive or negative offset
// - magnitude applies twice its value in LSBs, emulator once
// - calibration bits 2 to 0 always read zero
// - pin enable and control registers reset to zero
// - a 12-bit result comes from successive approximation
// - done flag sets regardless of mask; request needs flag and mask
// - completion loads result, clears run, sets done flag
// - completion in sleep wakes if enabled, else shuts converter off
module adc_control
	import adc_control_pkg::*;
#(
	parameter bit EMULATOR_STEP = 1'b0
) (
	input  wire logic                    REF_CLK,
	input  wire logic                    RESETN,
	input  wire logic                    PSEL,
	input  wire logic                    PENABLE,
	input  wire logic                    PWRITE,
	input  wire logic [7:0]              PADDR,
	input  wire logic [31:0]             PWDATA,
	output logic      [31:0]             PRDATA,
	output logic                         PREADY,
	output logic                         PSLVERR,
	input  wire logic                    RING_OSC_TICK,
	input  wire logic                    COMPARE_HIGH,
	input  wire logic                    COMPARATOR_PIN_REQUEST,
	input  wire logic                    PWM3_REQUEST,
	input  wire logic                    SLEEP,
	output logic      [7:0]              ANALOG_PIN,
	output logic                         PIN0_COMPARATOR,
	output logic                         PIN0_DIGITAL,
	output logic                         REFERENCE_EXTERNAL,
	output logic                         SHARED_PIN_REFERENCE,
	output logic                         SHARED_PIN_PWM,
	output logic                         SHARED_PIN_DIGITAL,
	output logic                         REFERENCE_POWER,
	output logic      [2:0]              CHANNEL_SELECT,
	output logic                         SAMPLE,
	output logic      [`RESULT_BITS-1:0] TRIAL_CODE,
	output logic      [`RESULT_BITS-1:0] RESULT,
	output logic                         CAL_ENABLE,
	output logic                         CAL_POSITIVE,
	output logic      [3:0]              CAL_OFFSET_LSB,
	output logic                         WAKE,
	output logic                         IRQ
);
	control_state_type s;
	control_state_type next_s;
	logic              access;
	logic              wr_take;
	logic              ctrl_write;
	logic              mask_write;
	logic              clear_write;
	logic              channel_open;
	logic [5:0]        limit;
	logic [31:0]       read_word;
	logic              read_ok;

	sar_link_if #(.WIDTH(`RESULT_BITS)) link ();

	sar_engine #(.WIDTH(`RESULT_BITS)) engine (
		.clk    (REF_CLK),
		.resetn (RESETN),
		.link   (link)
	);

	// one wait state so read data can come from a flip-flop
	assign access     = PSEL & PENABLE;
	assign wr_take    = access & PWRITE & s.ack;
	assign ctrl_write = wr_take & (PADDR == `ADDR_CONTROL);
	assign mask_write = wr_take & (PADDR == `ADDR_IRQ_ENABLE);
	assign clear_write = wr_take & (PADDR == `ADDR_CLEAR);
	assign channel_open = !s.conversion_run && !s.status_done;

	// start needs the done pulse masked: run falls one edge after it
	assign link.start   = s.conversion_run & ~link.busy & ~link.done;
	assign link.tick    = s.tick;
	assign link.compare = COMPARE_HIGH;

	always_comb begin
		case (s.clock_rate)
			`RATE_DIV4:  limit = `LIMIT_DIV4;
			`RATE_DIV64: limit = `LIMIT_DIV64;
			default:     limit = `LIMIT_DIV16;
		endcase
	end

	always_comb begin
		read_ok = 1'b1;
		read_word = '0;
		if (PADDR == `ADDR_PIN_ENABLE) begin
			read_word[7:0] = s.pin_enable;
		end else if (PADDR == `ADDR_CONTROL) begin
			read_word[7:0] = {s.reference_select, s.clock_rate,
				s.conversion_run, s.converter_power, s.channel};
		end else if (PADDR == `ADDR_CALIBRATION) begin
			read_word[7:0] = {s.calibration_enable, s.offset_positive,
				s.offset_magnitude, `CAL_RESERVED};
		end else if (PADDR == `ADDR_RESULT) begin
			read_word[`RESULT_BITS-1:0] = s.result;
		end else if (PADDR == `ADDR_STATUS) begin
			read_word[`BIT_DONE] = s.status_done;
		end else if (PADDR == `ADDR_CLEAR) begin
			read_word = '0;
		end else if (PADDR == `ADDR_IRQ_ENABLE) begin
			read_word[`BIT_DONE] = s.irq_enable_done;
		end else if (PADDR == `ADDR_WAKE) begin
			read_word[`BIT_WAKE_ENABLE] = s.converter_wake_enable;
		end else begin
			read_ok = 1'b0;
		end
	end

	always_comb begin
		next_s = s;
		next_s.wake = 1'b0;
		next_s.tick = 1'b0;

		// bus handshake and registered read data
		next_s.ack = access & ~s.ack;
		if (access && !s.ack) begin
			next_s.rdata = PWRITE ? '0 : read_word;
			next_s.error = ~read_ok;
		end

		// conversion clock enable
		if (s.clock_rate == `RATE_RING) begin
			next_s.divider = '0;
			next_s.tick = RING_OSC_TICK;
		end else if (s.divider >= limit) begin
			next_s.divider = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.divider = s.divider + 1'b1;
		end

		// completion: result and run; the done flag is set after the writes
		if (link.done) begin
			next_s.result = link.result;
			next_s.conversion_run = 1'b0;
		end

		// register writes
		if (wr_take) begin
			if (PADDR == `ADDR_PIN_ENABLE) begin
				next_s.pin_enable = PWDATA[7:0];
			end else if (PADDR == `ADDR_CONTROL) begin
				next_s.reference_select = PWDATA[`BIT_REF_SELECT];
				next_s.clock_rate = PWDATA[`BIT_RATE_HI:`BIT_RATE_LO];
				next_s.converter_power = PWDATA[`BIT_POWER];
				// only a set reaches the run bit
				if (PWDATA[`BIT_RUN]) begin
					next_s.conversion_run = 1'b1;
				end
				if (channel_open) begin
					next_s.channel =
						PWDATA[`BIT_CHANNEL_HI:`BIT_CHANNEL_LO];
				end
			end else if (PADDR == `ADDR_CALIBRATION) begin
				next_s.calibration_enable = PWDATA[`BIT_CAL_ENABLE];
				next_s.offset_positive = PWDATA[`BIT_CAL_SIGN];
				next_s.offset_magnitude = PWDATA[`BIT_MAG_HI:`BIT_MAG_LO];
			end else if (PADDR == `ADDR_CLEAR) begin
				if (PWDATA[`BIT_DONE]) begin
					next_s.status_done = 1'b0;
				end
			end else if (PADDR == `ADDR_IRQ_ENABLE) begin
				next_s.irq_enable_done = PWDATA[`BIT_DONE];
			end else if (PADDR == `ADDR_WAKE) begin
				next_s.converter_wake_enable = PWDATA[`BIT_WAKE_ENABLE];
			end
		end

		// set wins over a clear in the same cycle, mask not consulted
		if (link.done) begin
			next_s.status_done = 1'b1;
		end

		// sleep completion: wake, or shut the converter off
		if (link.done && SLEEP) begin
			if (s.converter_wake_enable) begin
				next_s.wake = 1'b1;
			end else begin
				next_s.shutoff = 1'b1;
			end
		end
		if (!SLEEP) begin
			next_s.shutoff = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// per-pin routing; pin 0 yields to the comparator output
	genvar pin;
	generate
		for (pin = 0; pin < `PIN_COUNT; pin++) begin : g_pin
			if (pin == 0) begin : g_shared
				assign ANALOG_PIN[pin] = s.pin_enable[pin] &
					~COMPARATOR_PIN_REQUEST;
			end else begin : g_plain
				assign ANALOG_PIN[pin] = s.pin_enable[pin];
			end
		end
	endgenerate

	assign PIN0_COMPARATOR = COMPARATOR_PIN_REQUEST;
	assign PIN0_DIGITAL = ~COMPARATOR_PIN_REQUEST & ~s.pin_enable[0];

	// software must drop the pwm request; the reference wins regardless
	assign REFERENCE_EXTERNAL   = s.reference_select;
	assign SHARED_PIN_REFERENCE = s.reference_select;
	assign SHARED_PIN_PWM       = ~s.reference_select & PWM3_REQUEST;
	assign SHARED_PIN_DIGITAL   = ~s.reference_select & ~PWM3_REQUEST;

	assign REFERENCE_POWER = s.converter_power & ~s.shutoff;
	assign CHANNEL_SELECT  = s.channel;
	assign SAMPLE          = link.sample;
	assign TRIAL_CODE      = link.trial;
	assign RESULT          = s.result;

	assign CAL_ENABLE     = s.calibration_enable;
	assign CAL_POSITIVE   = s.offset_positive;
	assign CAL_OFFSET_LSB = EMULATOR_STEP ? {1'b0, s.offset_magnitude}
		: {s.offset_magnitude, 1'b0};

	assign WAKE    = s.wake;
	assign IRQ     = s.status_done & s.irq_enable_done;
	assign PRDATA  = s.rdata;
	assign PREADY  = s.ack;
	assign PSLVERR = s.ack & s.error;

	a_channel_held: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		!channel_open |=> $stable(s.channel))
		else $error("channel changed while busy or flagged");

	a_blocked_write: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		ctrl_write && !channel_open |=>
		s.converter_power == $past(PWDATA[`BIT_POWER]))
		else $error("blocked channel write dropped other bits");

	a_run_sticky: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		s.conversion_run && !link.done |=> s.conversion_run)
		else $error("run bit cleared without completion");

	a_run_set: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		ctrl_write && PWDATA[`BIT_RUN] |=> s.conversion_run)
		else $error("software set of the run bit lost");

	a_done_clears: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		link.done && !(ctrl_write && PWDATA[`BIT_RUN]) |=>
		!s.conversion_run && s.status_done && s.result == $past(link.result))
		else $error("completion effects missing");

	// a mask write in the completion cycle legally changes the outcome
	a_irq_follows: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		link.done && s.irq_enable_done && !mask_write |=> IRQ)
		else $error("enabled completion raised no request");

	a_flag_unmasked: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		link.done && !s.irq_enable_done && !mask_write
		|=> s.status_done && !IRQ)
		else $error("flag not set or masked request leaked");

	a_flag_clear: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		clear_write && PWDATA[`BIT_DONE] && !link.done |=> !s.status_done)
		else $error("done flag not cleared by software");

	a_sleep_off: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		link.done && SLEEP && !s.converter_wake_enable ##1 SLEEP
		|-> !REFERENCE_POWER && !WAKE)
		else $error("converter stayed on after sleep completion");

	a_sleep_wake: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		link.done && SLEEP && s.converter_wake_enable |=> WAKE ##1 !WAKE)
		else $error("wake pulse missing or too long");

	a_power_back: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		!SLEEP |=> REFERENCE_POWER == s.converter_power)
		else $error("reference power not restored after sleep");

	a_cal_zero: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		access && !s.ack && !PWRITE && PADDR == `ADDR_CALIBRATION
		|=> PREADY && PRDATA[2:0] == `CAL_RESERVED)
		else $error("reserved calibration bits not zero");

	a_ready_wait: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		access && !s.ack |=> PREADY ##1 !PREADY)
		else $error("ready not after exactly one wait state");

	a_shared_ref: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		s.reference_select |-> SHARED_PIN_REFERENCE && !SHARED_PIN_PWM
		&& !SHARED_PIN_DIGITAL)
		else $error("shared pin not given to reference");

	a_pin0_order: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		COMPARATOR_PIN_REQUEST |-> !ANALOG_PIN[0] && !PIN0_DIGITAL)
		else $error("pin 0 not given to comparator");

	a_ring_tick: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		s.clock_rate == `RATE_RING && RING_OSC_TICK |=> s.tick)
		else $error("ring oscillator tick not passed on");

	a_rate_div4: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		s.tick && s.clock_rate == `RATE_DIV4 ##1
		(s.clock_rate == `RATE_DIV4) [*4] |-> s.tick)
		else $error("divide by 4 tick spacing wrong");

endmodule : adc_control

// >>> verif/analog_core_model.sv
// behavioural analog side: channel mux, comparator, ring oscillator
// assumes the bench drives one level per channel and holds it per run
module analog_core_model #(
	parameter int RING_PERIOD = 10
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [7:0][11:0] levels,
	input  wire logic [2:0]       channel,
	input  wire logic [11:0]      trial_code,
	output logic                  compare_high,
	output logic                  ring_tick
);
	int count;

	// only the selected channel reaches the comparator
	assign compare_high = levels[channel] >= trial_code;

	// free-running ring oscillator, one pulse per period
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= 0;
			ring_tick <= 1'b0;
		end else begin
			count <= (count == RING_PERIOD - 1) ? 0 : count + 1;
			ring_tick <= (count == RING_PERIOD - 1);
		end
	end
endmodule : analog_core_model

// >>> verif/tb.sv
// self-checking bench: APB master, analog model, random conversions
// assumes the register map header is on the include path
`include "adc_control_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic             ref_clk = 1'b0;
	logic             resetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0000_0000;
	logic             cmp_req = 1'b0;
	logic             pwm3_req = 1'b0;
	logic             sleep = 1'b0;
	logic [7:0][11:0] levels = '0;
	logic [31:0]      prdata;
	logic             pready, pslverr, ring_tick, compare_high, sample;
	logic [7:0]       analog_pin;
	logic             pin0_cmp, pin0_dig, ref_ext, sh_ref, sh_pwm, sh_dig;
	logic             ref_power, cal_en, cal_pos, wake, irq;
	logic [2:0]       channel;
	logic [11:0]      trial, result;
	logic [3:0]       cal_lsb;
	int               err_count = 0;
	int               n_tests = 0;
	int               seed = 71;
	int               cyc = 0;
	int               wake_cnt = 0;
	int               sample_cnt = 0;

	adc_control u_adc_control (.REF_CLK(ref_clk), .RESETN(resetn),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RING_OSC_TICK(ring_tick),
		.COMPARE_HIGH(compare_high), .COMPARATOR_PIN_REQUEST(cmp_req),
		.PWM3_REQUEST(pwm3_req), .SLEEP(sleep), .ANALOG_PIN(analog_pin),
		.PIN0_COMPARATOR(pin0_cmp), .PIN0_DIGITAL(pin0_dig),
		.REFERENCE_EXTERNAL(ref_ext), .SHARED_PIN_REFERENCE(sh_ref),
		.SHARED_PIN_PWM(sh_pwm), .SHARED_PIN_DIGITAL(sh_dig),
		.REFERENCE_POWER(ref_power), .CHANNEL_SELECT(channel),
		.SAMPLE(sample), .TRIAL_CODE(trial), .RESULT(result),
		.CAL_ENABLE(cal_en), .CAL_POSITIVE(cal_pos),
		.CAL_OFFSET_LSB(cal_lsb), .WAKE(wake), .IRQ(irq));

	analog_core_model u_analog_core_model (.clk(ref_clk), .resetn(resetn),
		.levels(levels), .channel(channel), .trial_code(trial),
		.compare_high(compare_high), .ring_tick(ring_tick));

	always #2 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (wake === 1'b1)
			wake_cnt <= wake_cnt + 1;
		if (sample === 1'b1)
			sample_cnt <= sample_cnt + 1;
	end

	task automatic stop_test;
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask : check

	// one transfer; an idle cycle after it so no strobe toggles twice
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no wait limit here: a hung slave is caught by the watchdog
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(a, 1'b0, 32'h0000_0000, r, e);
	endtask : rd

	function automatic int divider(input logic [1:0] rate);
		return rate == 2'h0 ? 16 : rate == 2'h1 ? 4 : rate == 2'h2 ? 64 : 10;
	endfunction : divider

	initial begin
		#(60000 * 4);
		err_count++;
		stop_test();
	end

	initial begin
		logic [31:0] r;
		logic        e, c, en, sg, ie, we;
		logic [7:0]  v, ctl;
		logic [2:0]  ch;
		logic [1:0]  rate;
		int          t0, w0, s0, dur, div;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(`ADDR_PIN_ENABLE, r);
		check("pin_enable_rst", r, 32'h0000_0000);
		rd(`ADDR_CONTROL, r);
		check("control_rst", r, 32'h0000_0000);
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 8'hFF : 8'($random(seed));
			c = (k < 2) ? 1'b1 : 1'($random(seed));
			cmp_req <= c;
			wr(`ADDR_PIN_ENABLE, 32'(v));
			check("analog_pin", 32'(analog_pin),
				32'({v[7:1], v[0] & ~c}));
			check("pin0_owner", 32'({pin0_cmp, pin0_dig}),
				32'({c, ~c & ~v[0]}));
			rd(`ADDR_PIN_ENABLE, r);
			check("pin_enable_rd", r, 32'(v));
		end
		for (int k = 0; k < 4; k++) begin
			pwm3_req <= k[0];
			wr(`ADDR_CONTROL, 32'({k[1], 7'h08}));
			check("ref_external", 32'(ref_ext), 32'(k[1]));
			check("shared_pin", 32'({sh_ref, sh_pwm, sh_dig}),
				k[1] ? 32'h4 : k[0] ? 32'h2 : 32'h1);
			check("ref_power_on", 32'(ref_power), 32'h1);
		end
		pwm3_req <= 1'b0;
		wr(`ADDR_CONTROL, 32'h0000_0000);
		check("ref_power_off", 32'(ref_power), 32'h0);
		for (int k = 0; k < 8; k++) begin
			en = 1'($random(seed));
			sg = 1'($random(seed));
			wr(`ADDR_CALIBRATION, 32'({en, sg, 3'(k), 3'h7}));
			check("cal_out", 32'({cal_en, cal_pos, cal_lsb}),
				32'({en, sg, 4'(2 * k)}));
			rd(`ADDR_CALIBRATION, r);
			check("cal_rd", r, 32'({en, sg, 3'(k), 3'h0}));
		end
		apb(8'h20, 1'b0, 32'h0000_0000, r, e);
		check("unmapped_err", 32'(e), 32'h1);
		check("unmapped_rd", r, 32'h0000_0000);
		for (int k = 0; k < 8; k++) begin
			rate = 2'(k);
			ch = 3'($random(seed));
			ie = k[0];
			we = k[1] ^ k[0];
			for (int j = 0; j < 8; j++)
				levels[j] <= 12'($random(seed));
			sleep <= k[2];
			wr(`ADDR_IRQ_ENABLE, 32'(ie));
			wr(`ADDR_WAKE, 32'(we));
			w0 = wake_cnt;
			s0 = sample_cnt;
			ctl = {1'b0, rate, 1'b1, 1'b1, ch};
			wr(`ADDR_CONTROL, 32'(ctl));
			t0 = cyc;
			check("channel", 32'(channel), 32'(ch));
			// run cleared and channel moved while busy: both refused
			wr(`ADDR_CONTROL, 32'(ctl ^ 8'h11));
			rd(`ADDR_CONTROL, r);
			check("ctl_busy", r, 32'(ctl));
			do begin
				rd(`ADDR_STATUS, r);
			end while (r[0] !== 1'b1);
			dur = cyc - t0;
			div = divider(rate);
			check("conv_time", 32'(dur >= 12 * div && dur <= 15 * div + 16),
				32'h1);
			// acquisition lasts until the first conversion tick
			check("sample_time", 32'(sample_cnt - s0 >= 1 &&
				sample_cnt - s0 <= div), 32'h1);
			check("result", 32'(result), 32'(levels[ch]));
			rd(`ADDR_RESULT, r);
			check("result_rd", r, 32'(levels[ch]));
			rd(`ADDR_CONTROL, r);
			check("run_cleared", r, 32'(ctl & 8'hEF));
			check("irq", 32'(irq), 32'(ie));
			check("wake", 32'(wake_cnt - w0), 32'(k[2] & we));
			check("ref_power_sleep", 32'(ref_power),
				32'(!(k[2] && !we)));
			sleep <= 1'b0;
			wr(`ADDR_CONTROL, 32'((ctl & 8'hEF) ^ 8'h86));
			rd(`ADDR_CONTROL, r);
			check("ctl_done", r, 32'((ctl & 8'hEF) ^ 8'h80));
			check("ref_power_awake", 32'(ref_power), 32'h1);
			wr(`ADDR_IRQ_ENABLE, 32'h0000_0000);
			check("irq_masked", 32'(irq), 32'h0);
			rd(`ADDR_STATUS, r);
			check("done_sticky", r, 32'h1);
			wr(`ADDR_CLEAR, 32'h0000_0001);
			rd(`ADDR_STATUS, r);
			check("done_clear", r, 32'h0);
		end
		stop_test();
	end
endmodule : tb
